/* File: acs_pkg.sv */
// Shared constants and types for the conversion sequencer
package acs_pkg;
   // -------------------------------------------------
   // Register byte offsets
   // -------------------------------------------------
   localparam logic [7:0] ACS_CTRL_A_OFS = 8'h00;
   localparam logic [7:0] ACS_CTRL_B_OFS = 8'h04;
   localparam logic [7:0] ACS_PWR_OFS    = 8'h08;
   localparam logic [7:0] ACS_CHAN_OFS   = 8'h0c;
   localparam logic [7:0] ACS_RES_LO_OFS = 8'h10;
   localparam logic [7:0] ACS_RES_HI_OFS = 8'h14;
   localparam logic [7:0] ACS_STAT_OFS   = 8'h18;
   // -------------------------------------------------
   // Field positions
   // -------------------------------------------------
   localparam int ACS_A_EN    = 7;
   localparam int ACS_A_START = 6;
   localparam int ACS_A_ATE   = 5;
   localparam int ACS_A_FLAG  = 4;
   localparam int ACS_A_PS    = 0;
   localparam int ACS_B_TS    = 0;
   localparam int ACS_B_DIFF  = 4;
   localparam int ACS_CHAN_W  = 5;
   localparam int ACS_PS_W    = 3;
   localparam int ACS_PSC_W   = 8;
   // -------------------------------------------------
   // Reset values and codes
   // -------------------------------------------------
   localparam logic [2:0] ACS_PS_RST  = 3'h0;
   localparam logic [2:0] ACS_TS_RST  = 3'h0;
   localparam logic [2:0] ACS_TS_FREE = 3'h0;
   localparam logic       ACS_PWR_RST = 1'h0;
   localparam int         ACS_SYNC_CYC = 3;
   // -------------------------------------------------
   // Conversion lengths in converter half cycles
   // -------------------------------------------------
   localparam logic [5:0] ACS_TOT_NORM  = 6'h1a; // 13
   localparam logic [5:0] ACS_SH_NORM   = 6'h03; // 1.5
   localparam logic [5:0] ACS_TOT_FIRST = 6'h32; // 25
   localparam logic [5:0] ACS_SH_FIRST  = 6'h1b; // 13.5
   localparam logic [5:0] ACS_TOT_AUTO  = 6'h1b; // 13.5
   localparam logic [5:0] ACS_SH_AUTO   = 6'h04; // 2
   localparam logic [5:0] ACS_TOT_DIFF  = 6'h1c; // 14
   localparam logic [5:0] ACS_SH_DIFF   = 6'h05; // 2.5
   // -------------------------------------------------
   // Types
   // -------------------------------------------------
   typedef enum logic {ACS_IDLE, ACS_CONV} acs_state_e;
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } acs_apb_req_s;
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } acs_apb_rsp_s;
   typedef struct packed {
      logic                  enable;
      logic                  sample;
      logic                  done;
      logic [ACS_CHAN_W-1:0] channel;
   } acs_core_s;
   typedef struct packed {
      logic [ACS_PSC_W-1:0] cnt;
   } acs_psc_s;
   typedef struct packed {
      logic [ACS_SYNC_CYC-1:0] pipe;
   } acs_trg_s;
endpackage : acs_pkg

/* File: acs_prescaler.sv */
// Converter clock prescaler producing rise and fall ticks
`timescale 1ns/10ps
module acs_prescaler (
   // Clock and reset
   input  wire logic                     clock,
   input  wire logic                     arst_n,
   // Control
   input  wire logic                     clr,
   input  wire logic [acs_pkg::ACS_PS_W-1:0] sel,
   // Ticks
   output logic                          rise_tick,
   output logic                          fall_tick
);
   import acs_pkg::*;
   acs_psc_s               s_reg, s_next;
   logic [ACS_PSC_W:0]     ratio;
   logic [ACS_PSC_W-1:0]   top;
   logic [ACS_PSC_W-1:0]   half;

   // Ratio is two to the power sel plus one
   always_comb begin
      ratio     = (ACS_PSC_W+1)'(2) << sel;
      top       = ACS_PSC_W'(ratio - (ACS_PSC_W+1)'(1));
      half      = ratio[ACS_PSC_W:1] - ACS_PSC_W'(1);
      rise_tick = !clr && s_reg.cnt == top;
      fall_tick = !clr && s_reg.cnt == half;
      s_next    = s_reg;
      if (clr || s_reg.cnt == top) begin
         s_next.cnt = '0;
      end else begin
         s_next.cnt = s_reg.cnt + ACS_PSC_W'(1);
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   held_in_reset_a: assert property (@(posedge clock) disable iff (!arst_n)
      clr |=> s_reg.cnt == '0) else $error("prescaler not held");
endmodule : acs_prescaler

/* File: acs_trigger.sv */
// Trigger source selection and rising edge detection
`timescale 1ns/10ps
module acs_trigger #(
   parameter int NSRC = 8
) (
   // Clock and reset
   input  wire logic                    clock,
   input  wire logic                    arst_n,
   // Sources
   input  wire logic [NSRC-1:0]         src_in,
   input  wire logic [$clog2(NSRC)-1:0] sel,
   // Edge out
   output logic                         trig_edge
);
   import acs_pkg::*;
   acs_trg_s s_reg, s_next;

   // Delay line gives the fixed three-cycle sync latency
   always_comb begin
      s_next      = s_reg;
      s_next.pipe = {s_reg.pipe[ACS_SYNC_CYC-2:0], src_in[sel]};
      // Level must drop before a new edge counts, so a held flag
      // cannot retrigger until software clears it
      trig_edge   = s_reg.pipe[1] && !s_reg.pipe[2];
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule : acs_trigger

/* File: acs_sequencer.sv */
// Conversion sequencer: APB registers, start logic, timing
//
// What this block does
// - Start bit write begins one conversion when power reduction is off
// - Channel change during a conversion waits until it completes
// - Auto trigger enable lets the selected hardware source start runs
// - Rising trigger edge resets prescaler and starts a conversion
// - Held trigger level or edges during a conversion start nothing
// - Source flags set regardless of masking; must clear to retrigger
// - Complete flag as source gives free running after software start
// - Start bit reads one while busy; writing one while busy is ignored
// - Prescaler runs while enabled, held in reset while disabled
// - Software start begins on next rising converter clock edge
// - Normal conversion 13 cycles, first after enable 25 cycles
// - Sampling at 1.5 cycles, or 13.5 on the first conversion
// - Completion stores result, sets flag, clears start in single mode
// - Triggered runs sample two cycles after edge, 13.5 cycles long
// - Free running restarts at once, start bit stays high
// - Differential runs align to half-rate clock, 13 or 14 cycles
// - Channel takes effect only when enabled; no power when disabled
// - Low byte read blocks result updates until high byte read
`timescale 1ns/10ps
module acs_sequencer (
   // Clock and reset
   input  wire logic                 clock,
   input  wire logic                 arst_n,
   // APB slave
   input  wire acs_pkg::acs_apb_req_s apb_req,
   output acs_pkg::acs_apb_rsp_s     apb_rsp,
   // Hardware trigger sources 1 to 7
   input  wire logic [6:0]           trig_in,
   // Analog core
   input  wire logic [9:0]           core_result,
   output acs_pkg::acs_core_s        core
);
   import acs_pkg::*;

   // -------------------------------------------------
   // State
   // -------------------------------------------------
   typedef struct packed {
      acs_state_e            st;
      logic                  en;
      logic                  power_reduction_reg;
      logic                  ate;
      logic                  flag;
      logic                  strt_pend;
      logic                  first;
      logic                  diff;
      logic                  lock;
      logic                  half_clk;
      logic                  sample;
      logic                  done;
      logic [ACS_PS_W-1:0]   ps;
      logic [2:0]            ts;
      logic [ACS_CHAN_W-1:0] chan_pend;
      logic [ACS_CHAN_W-1:0] chan_act;
      logic [5:0]            hcnt;
      logic [5:0]            tot;
      logic [5:0]            sh;
      logic [7:0]            res_lo;
      logic [1:0]            res_hi;
      logic [31:0]           rdata;
   } acs_seq_s;

   acs_seq_s    s_reg, s_next;
   logic        rise_tick;
   logic        fall_tick;
   logic        tick;
   logic        psc_clr;
   logic        trig_edge;
   logic        en_eff;
   logic        busy;
   logic        trig_go;
   logic        sw_go;
   logic        free_mode;
   logic        done;
   logic        wr;
   logic        rd;
   logic        rd_start;
   logic [5:0]  hc_inc;
   logic [31:0] rd_val;
   logic [31:0] w;

   // -------------------------------------------------
   // Address decode
   // -------------------------------------------------
   function automatic logic map_hit(input logic [7:0] a);
      case (a)
         ACS_CTRL_A_OFS, ACS_CTRL_B_OFS, ACS_PWR_OFS, ACS_CHAN_OFS,
         ACS_RES_LO_OFS, ACS_RES_HI_OFS, ACS_STAT_OFS: map_hit = 1'b1;
         default: map_hit = 1'b0;
      endcase
   endfunction : map_hit

   // -------------------------------------------------
   // Submodules
   // -------------------------------------------------
   acs_prescaler u_psc (
      .clock     (clock),
      .arst_n    (arst_n),
      .clr       (psc_clr),
      .sel       (s_reg.ps),
      .rise_tick (rise_tick),
      .fall_tick (fall_tick)
   );

   // Slot zero is the complete flag, handled as free running below
   acs_trigger #(.NSRC(8)) u_trg (
      .clock     (clock),
      .arst_n    (arst_n),
      .src_in    ({trig_in, 1'b0}),
      .sel       (s_reg.ts),
      .trig_edge (trig_edge)
   );

   // -------------------------------------------------
   // Start and completion terms
   // -------------------------------------------------
   assign en_eff    = s_reg.en && !s_reg.power_reduction_reg;
   assign busy      = s_reg.st == ACS_CONV;
   assign free_mode = s_reg.ate && s_reg.ts == ACS_TS_FREE;
   // Edges while busy are simply dropped, not queued
   assign trig_go   = !busy && en_eff && s_reg.ate &&
                      s_reg.ts != ACS_TS_FREE && trig_edge;
   assign sw_go     = !busy && en_eff && s_reg.strt_pend &&
                      rise_tick && !trig_go;
   assign psc_clr   = !en_eff || trig_go;
   assign tick      = rise_tick || fall_tick;
   assign hc_inc    = s_reg.hcnt + 6'h01;
   assign done      = busy && tick && hc_inc == s_reg.tot;
   assign rd_start  = s_reg.strt_pend || busy;

   // APB strobes, effects only in the access phase
   assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
   assign rd = apb_req.psel && apb_req.penable && !apb_req.pwrite;
   assign w  = apb_req.pwdata;

   // Zero wait states; unmapped addresses answer with an error
   assign apb_rsp.pready  = 1'b1;
   assign apb_rsp.pslverr = apb_req.psel && apb_req.penable &&
                            !map_hit(apb_req.paddr);
   assign apb_rsp.prdata  = s_reg.rdata;

   // Core side; power is gated by the effective enable
   assign core.enable  = en_eff;
   assign core.sample  = s_reg.sample;
   assign core.done    = s_reg.done;
   assign core.channel = s_reg.chan_act;

   // -------------------------------------------------
   // Read mux
   // -------------------------------------------------
   always_comb begin
      rd_val = '0;
      case (apb_req.paddr)
         ACS_CTRL_A_OFS: begin
            rd_val[ACS_A_EN]    = s_reg.en;
            rd_val[ACS_A_START] = rd_start;
            rd_val[ACS_A_ATE]   = s_reg.ate;
            rd_val[ACS_A_FLAG]  = s_reg.flag;
            rd_val[ACS_A_PS+:ACS_PS_W] = s_reg.ps;
         end
         ACS_CTRL_B_OFS: begin
            rd_val[ACS_B_TS+:3] = s_reg.ts;
            rd_val[ACS_B_DIFF]  = s_reg.diff;
         end
         ACS_PWR_OFS:    rd_val[0] = s_reg.power_reduction_reg;
         ACS_CHAN_OFS: begin
            rd_val[ACS_CHAN_W-1:0] = s_reg.chan_pend;
            rd_val[8+:ACS_CHAN_W]  = s_reg.chan_act;
         end
         ACS_RES_LO_OFS: rd_val[7:0] = s_reg.res_lo;
         ACS_RES_HI_OFS: rd_val[1:0] = s_reg.res_hi;
         ACS_STAT_OFS:   rd_val[3:0] = {s_reg.lock, s_reg.half_clk,
                                        s_reg.first, busy};
         default:        rd_val = '0;
      endcase
   end

   // -------------------------------------------------
   // Next state
   // -------------------------------------------------
   always_comb begin
      s_next        = s_reg;
      s_next.sample = 1'b0;
      s_next.done   = 1'b0;
      // Half-rate clock follows converter clock rising edges
      if (psc_clr) begin
         s_next.half_clk = 1'b0;
      end else if (rise_tick) begin
         s_next.half_clk = !s_reg.half_clk;
      end
      // Register writes
      if (wr) begin
         case (apb_req.paddr)
            ACS_CTRL_A_OFS: begin
               s_next.en  = w[ACS_A_EN];
               s_next.ate = w[ACS_A_ATE];
               s_next.ps  = w[ACS_A_PS+:ACS_PS_W];
               if (w[ACS_A_EN] && !s_reg.en) begin
                  s_next.first = 1'b1;
               end
               if (w[ACS_A_FLAG]) begin
                  s_next.flag = 1'b0;
               end
               if (w[ACS_A_START] && w[ACS_A_EN] && !s_reg.power_reduction_reg &&
                   !busy) begin
                  s_next.strt_pend = 1'b1;
               end
            end
            ACS_CTRL_B_OFS: begin
               s_next.ts   = w[ACS_B_TS+:3];
               s_next.diff = w[ACS_B_DIFF];
            end
            ACS_PWR_OFS:  s_next.power_reduction_reg = w[0];
            ACS_CHAN_OFS: s_next.chan_pend = w[ACS_CHAN_W-1:0];
            default: ;
         endcase
      end
      // Byte pair lock: low read freezes, high read frees
      if (rd && apb_req.paddr == ACS_RES_LO_OFS) begin
         s_next.lock = 1'b1;
      end
      if (rd && apb_req.paddr == ACS_RES_HI_OFS) begin
         s_next.lock = 1'b0;
      end
      // Channel tracks the pending value while idle and enabled, and is reloaded at a free running restart
      if (!busy && en_eff) begin
         s_next.chan_act = s_reg.chan_pend;
      end
      // Conversion sequencing
      case (s_reg.st)
         ACS_IDLE: begin
            if (trig_go || sw_go) begin
               s_next.st   = ACS_CONV;
               s_next.hcnt = '0;
               if (s_reg.first) begin
                  s_next.tot   = ACS_TOT_FIRST;
                  s_next.sh    = ACS_SH_FIRST;
                  s_next.first = 1'b0;
               end else if (trig_go) begin
                  s_next.tot = ACS_TOT_AUTO;
                  s_next.sh  = ACS_SH_AUTO;
               end else if (s_reg.diff && s_reg.half_clk) begin
                  s_next.tot = ACS_TOT_DIFF;
                  s_next.sh  = ACS_SH_DIFF;
               end else begin
                  s_next.tot = ACS_TOT_NORM;
                  s_next.sh  = ACS_SH_NORM;
               end
            end
         end
         ACS_CONV: begin
            if (tick) begin
               s_next.hcnt = hc_inc;
               if (hc_inc == s_reg.sh) begin
                  s_next.sample = 1'b1;
               end
            end
            if (done) begin
               s_next.done = 1'b1;
               s_next.flag = 1'b1;
               if (!s_reg.lock) begin
                  s_next.res_lo = core_result[7:0];
                  s_next.res_hi = core_result[9:8];
               end
               if (free_mode) begin
                  // Restart at once; diff runs here are always 14
                  s_next.hcnt     = '0;
                  s_next.chan_act = s_reg.chan_pend;
                  s_next.tot = s_reg.diff ? ACS_TOT_DIFF : ACS_TOT_NORM;
                  s_next.sh  = s_reg.diff ? ACS_SH_DIFF : ACS_SH_NORM;
               end else begin
                  s_next.st        = ACS_IDLE;
                  s_next.strt_pend = 1'b0;
               end
            end
         end
         default: s_next.st = ACS_IDLE;
      endcase
      // Disabling aborts any run in progress; a start written together
      // with the enable bit must survive the still-disabled cycle
      if (!en_eff) begin
         s_next.st   = ACS_IDLE;
         s_next.hcnt = '0;
         if (!s_next.en || s_next.power_reduction_reg) begin
            s_next.strt_pend = 1'b0;
         end
      end
      // Read data is captured in the setup phase
      if (apb_req.psel && !apb_req.penable) begin
         s_next.rdata = rd_val;
      end
   end

   // -------------------------------------------------
   // State register
   // -------------------------------------------------
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s_reg     <= '0;
         s_reg.st  <= ACS_IDLE;
         s_reg.power_reduction_reg <= ACS_PWR_RST;
         s_reg.ps  <= ACS_PS_RST;
         s_reg.ts  <= ACS_TS_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   // -------------------------------------------------
   // Checks
   // -------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   sequence trig_start_s;
      trig_go && psc_clr;
   endsequence
   sequence auto_run_s;
      busy && s_reg.hcnt == '0 && s_reg.tot == ACS_TOT_AUTO;
   endsequence

   start_reads_one_a: assert property (
      busy |-> rd_start) else $error("start bit low while busy");
   done_clears_start_a: assert property (
      done && !free_mode && en_eff |=> !s_reg.strt_pend && !busy)
      else $error("start not cleared at completion");
   done_sets_flag_a: assert property (
      done |=> s_reg.flag && s_reg.done) else $error("flag not set");
   trig_start_seq_a: assert property (
      trig_start_s ##1 1'b1 |-> auto_run_s or ($past(s_reg.first)))
      else $error("trigger did not start a run");
   busy_no_reset_a: assert property (
      busy && en_eff |-> !psc_clr) else $error("edge restarted prescaler");
   sw_on_tick_a: assert property (
      $rose(busy) |-> $past(rise_tick) || $past(trig_go))
      else $error("software start off clock edge");
   run_length_a: assert property (
      done |-> hc_inc == s_reg.tot && (s_reg.tot == ACS_TOT_NORM ||
      s_reg.tot == ACS_TOT_FIRST || s_reg.tot == ACS_TOT_AUTO ||
      s_reg.tot == ACS_TOT_DIFF)) else $error("bad conversion length");
   sample_point_a: assert property (
      s_reg.sample |-> busy && s_reg.hcnt == s_reg.sh)
      else $error("sample at wrong point");
   free_restart_a: assert property (
      done && free_mode && en_eff |=> busy && rd_start &&
      s_reg.hcnt == '0) else $error("free run did not restart");
   lock_holds_a: assert property (
      done && s_reg.lock |=> $stable(s_reg.res_lo) && s_reg.flag)
      else $error("locked result overwritten");
   chan_locked_a: assert property (
      busy && !done |=> $stable(s_reg.chan_act))
      else $error("channel changed mid conversion");
endmodule : acs_sequencer

/* File: acs_core_model.sv */
// Behavioural model of the analog sampling core
`timescale 1ns/10ps
module acs_core_model (
   // Clock and reset
   input  wire logic               clock,
   input  wire logic               arst_n,
   // Sequencer side
   input  wire acs_pkg::acs_core_s core,
   output logic [9:0]              core_result
);
   import acs_pkg::*;
   logic [9:0] held_reg;
   // Code comes from the channel seen at the sample point,
   // so a channel that switches too early shows in the result
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         held_reg <= 10'h000;
      end else if (core.sample) begin
         held_reg <= {core.channel, ~core.channel};
      end
   end
   // Powered down the core holds no valid code: show the inverse
   assign core_result = core.enable ? held_reg : ~held_reg;
endmodule : acs_core_model

/* File: acs_sequencer_tb_top.sv */
// Self-checking testbench for the conversion sequencer
`timescale 1ns/10ps
module acs_sequencer_tb_top;
   import acs_pkg::*;
   logic         clock;
   logic         arst_n;
   acs_apb_req_s apb_req;
   acs_apb_rsp_s apb_rsp;
   logic [6:0]   trig_in;
   logic [9:0]   core_result;
   acs_core_s    core;
   logic [31:0]  rd;
   logic         err;
   int           n_fail = 0;
   int           tests_run = 0;
   int           cyc = 0;
   int           n_done = 0;
   int           t_smp = 0;
   int           t0, t1, t2, t3, e1;
   acs_sequencer acs_sequencer_inst (.clock(clock), .arst_n(arst_n),
      .apb_req(apb_req), .apb_rsp(apb_rsp), .trig_in(trig_in),
      .core_result(core_result), .core(core));
   acs_core_model acs_core_model_inst (.clock(clock), .arst_n(arst_n),
      .core(core), .core_result(core_result));
   // ----------------------------------------
   // Clock, event stamps and shared tasks
   // ----------------------------------------
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   // Every sample gets a cycle stamp; every completion is counted
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (core.sample === 1'b1) t_smp <= cyc;
      if (core.done === 1'b1) n_done <= n_done + 1;
   end
   task automatic conclude();
      $display("Comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : conclude
   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic hang(input string nm);
      n_fail++;
      $display("ERROR %s expected event seen timeout", nm);
      conclude();
   endtask : hang
   // One APB transfer; an idle cycle follows so psel never toggles twice
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      k = 0;
      apb_req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clock);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge clock);
         k++;
      end while (apb_rsp.pready !== 1'b1 && k < 20);
      if (k >= 20) hang("pready");
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req <= '0;
      @(posedge clock);
   endtask : apb
   task automatic wait_done(input int lim, output int t);
      int n0;
      n0 = n_done;
      t = 0;
      while (n_done == n0) begin
         @(posedge clock);
         t++;
         if (t > lim) hang("done");
      end
      t = cyc;
   endtask : wait_done
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      apb(1'b0, ACS_CTRL_A_OFS, '0);
      check("ctrl_a_rst", rd, 32'h0);
      apb(1'b0, ACS_CTRL_B_OFS, '0);
      check("ctrl_b_rst", rd, {29'h0, ACS_TS_RST});
      apb(1'b0, ACS_PWR_OFS, '0);
      check("pwr_rst", rd, {31'h0, ACS_PWR_RST});
      apb(1'b0, 8'h1c, '0);
      check("unmapped_err", {31'h0, err}, 32'h1);
      $display("Test reset done");
   endtask : t_reset
   // Channel switch mid-run, result lock between low and high reads
   task automatic t_result();
      apb(1'b1, ACS_CHAN_OFS, 32'h1a);
      apb(1'b1, ACS_CTRL_A_OFS, 32'hc0);
      apb(1'b1, ACS_CHAN_OFS, 32'h05);
      apb(1'b0, ACS_CHAN_OFS, '0);
      check("chan_held", rd, 32'h1a05);
      apb(1'b0, ACS_CTRL_A_OFS, '0);
      check("start_busy", rd, 32'hc0);
      wait_done(200, t1);
      apb(1'b0, ACS_CTRL_A_OFS, '0);
      check("complete", rd, 32'h90);
      apb(1'b0, ACS_RES_LO_OFS, '0);
      check("res_lo", rd, 32'h45);
      apb(1'b1, ACS_CTRL_A_OFS, 32'hd0);
      wait_done(200, t1);
      apb(1'b0, ACS_CTRL_A_OFS, '0);
      check("flag_lost", rd, 32'h90);
      apb(1'b0, ACS_RES_HI_OFS, '0);
      check("res_hi_kept", rd, 32'h3);
      apb(1'b0, ACS_RES_LO_OFS, '0);
      check("res_lo_kept", rd, 32'h45);
      apb(1'b0, ACS_RES_HI_OFS, '0);
      apb(1'b1, ACS_CTRL_A_OFS, 32'h90);
      apb(1'b1, ACS_PWR_OFS, 32'h1);
      apb(1'b1, ACS_CTRL_A_OFS, 32'hc0);
      check("pwr_off", {31'h0, core.enable}, 32'h0);
      repeat (100) @(posedge clock);
      apb(1'b0, ACS_CTRL_A_OFS, '0);
      check("pwr_no_run", rd, 32'h80);
      apb(1'b1, ACS_PWR_OFS, 32'h0);
      apb(1'b1, ACS_CTRL_A_OFS, 32'h10);
      $display("Test result done");
   endtask : t_result
   // Free running at one prescaler code; the period exposes the ratio
   task automatic t_free(input logic [2:0] ps, input logic diff);
      int h;
      int d;
      h = 1 << ps;
      apb(1'b1, ACS_CTRL_B_OFS, {27'h0, diff, 4'h0});
      apb(1'b1, ACS_CTRL_A_OFS, {24'h0, 5'h1c, ps});
      t0 = cyc;
      wait_done(60 * h + 20, t1);
      e1 = t1 - t_smp;
      d = t1 - t0 - 50 * h;
      wait_done(40 * h + 20, t2);
      if (!diff) check("smp_pos", 32'(t2 - t_smp), 32'(e1));
      if (!diff) check("first", {31'h0, d >= -4 && d <= 2 * h + 4}, 1);
      apb(1'b0, ACS_CTRL_A_OFS, '0);
      check("free_busy", {31'h0, rd[6]}, 32'h1);
      wait_done(40 * h + 20, t3);
      check("period", 32'(t3 - t2), 32'((diff ? 28 : 26) * h));
      apb(1'b1, ACS_CTRL_A_OFS, 32'h10);
      $display("Test free run code %0d diff %0d done", ps, diff);
   endtask : t_free
   // Every trigger source; a held level and a second edge start nothing
   task automatic t_trig();
      int k;
      int n0;
      apb(1'b1, ACS_CTRL_B_OFS, 32'h1);
      apb(1'b1, ACS_CTRL_A_OFS, 32'hc3);
      wait_done(500, t1);
      n0 = n_done;
      trig_in <= 7'h01;
      repeat (4) @(posedge clock);
      trig_in <= 7'h00;
      repeat (300) @(posedge clock);
      check("no_auto", 32'(n_done - n0), 32'h0);
      apb(1'b1, ACS_CTRL_A_OFS, 32'hb3);
      for (k = 1; k < 8; k++) begin
         apb(1'b1, ACS_CTRL_B_OFS, 32'(k));
         n0 = n_done;
         t0 = cyc;
         trig_in <= 7'(1 << (k - 1));
         repeat (20) @(posedge clock);
         trig_in <= 7'h00;
         repeat (2) @(posedge clock);
         trig_in <= 7'(1 << (k - 1));
         apb(1'b0, ACS_CTRL_A_OFS, '0);
         check("trig_busy", {31'h0, rd[6]}, 32'h1);
         wait_done(400, t1);
         t2 = t_smp - t0 - 32;
         check("trig_smp", {31'h0, t2 >= 0 && t2 <= 7}, 1);
         repeat (300) @(posedge clock);
         check("trig_once", 32'(n_done - n0), 32'h1);
         trig_in <= 7'h00;
         @(posedge clock);
      end
      apb(1'b1, ACS_CTRL_A_OFS, 32'h10);
      $display("Test trigger done");
   endtask : t_trig
   // Main sequence
   initial begin
      arst_n = 1'b0;
      apb_req = '0;
      trig_in = 7'h00;
      repeat (6) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      t_reset();
      t_result();
      for (int p = 0; p < 8; p++) t_free(3'(p), 1'b0);
      t_free(3'h0, 1'b1);
      t_trig();
      conclude();
   end
endmodule : acs_sequencer_tb_top
